// ==== hw/ccpt_pkg.sv ====
package ccpt_pkg;
    // Register indices; the byte address of each register is four times its index.
    localparam logic [7:0] IDX_TSC = 8'h51;
    localparam logic [7:0] IDX_CNT_HI = 8'h52;
    localparam logic [7:0] IDX_CNT_LO = 8'h53;
    localparam logic [7:0] IDX_MOD_HI = 8'h54;
    localparam logic [7:0] IDX_MOD_LO = 8'h55;
    localparam logic [7:0] IDX_SC0 = 8'h56;
    localparam logic [7:0] IDX_CH0_HI = 8'h57;
    localparam logic [7:0] IDX_CH0_LO = 8'h58;
    localparam logic [7:0] IDX_SC1 = 8'h59;
    localparam logic [7:0] IDX_CH1_HI = 8'h5A;
    localparam logic [7:0] IDX_CH1_LO = 8'h5B;

    // Field positions in the timer status and control register.
    localparam int TSC_FLAG = 7;
    localparam int TSC_IRQEN = 6;
    localparam int TSC_HALT = 5;
    localparam int TSC_CLEAR = 4;
    localparam int TSC_PS_HI = 2;
    localparam int TSC_PS_LO = 0;

    // Field positions in a channel status and control register.
    localparam int SC_FLAG = 7;
    localparam int SC_IRQEN = 6;
    localparam int SC_BUF = 5;
    localparam int SC_MSA = 4;
    localparam int SC_ELS_HI = 3;
    localparam int SC_ELS_LO = 2;
    localparam int SC_TOV = 1;
    localparam int SC_MAX = 0;

    // Reset values.
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [2:0] PS_RST = 3'h0;
    localparam logic HALT_RST = 1'b1;
    localparam logic [6:0] SC_RST = 7'h00;

    // Clock select code for the external clock pin.
    localparam logic [2:0] PS_EXT = 3'h7;

    // Edge/level field encodings.
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_ANY = 2'h3;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
endpackage : ccpt_pkg

// ==== hw/ccpt_evflag.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccpt_evflag (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic event_set,
    input wire logic status_read,
    input wire logic status_write,
    input wire logic write_bit,
    output var logic flag_r
);
    logic arm_r;

    // A read that sees the flag set arms the clear; any new event disarms it.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            arm_r <= 1'b0;
        end else if (event_set) begin
            arm_r <= 1'b0;
        end else if (status_read && flag_r) begin
            arm_r <= 1'b1;
        end else if (status_write) begin
            arm_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (event_set) begin
            flag_r <= 1'b1;
        end else if (status_write && !write_bit && arm_r) begin
            flag_r <= 1'b0;
        end
    end

    property p_set_wins;
        @(posedge clock) disable iff (!rst_n) event_set |=> flag_r;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event did not set the flag.");

    property p_no_blind_clear;
        @(posedge clock) disable iff (!rst_n) (flag_r && !arm_r) |=> flag_r;
    endproperty
    a_no_blind_clear: assert property (p_no_blind_clear) else $error("Flag cleared without a read.");

    property p_clear_seq;
        @(posedge clock) disable iff (!rst_n)
            (arm_r && status_write && !write_bit && !event_set) |=> !flag_r;
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("Read then zero write did not clear.");

    property p_one_ignored;
        @(posedge clock) disable iff (!rst_n) (flag_r && status_write && write_bit) |=> flag_r;
    endproperty
    a_one_ignored: assert property (p_one_ignored) else $error("Writing one changed the flag.");
endmodule : ccpt_evflag
`default_nettype wire

// ==== hw/ccpt_timer.sv ====
// What this block does
// - Halt and clear written together stop the counter at zero.
// - Clock select picks bus clock divided 1 to 64, or external pin.
// - Counter high read latches low byte until low byte is read.
// - Reset and the clear control zero the counter.
// - Count equal to modulo sets wrap flag, restarts from zero.
// - Modulo high write suppresses wrap flag until low write; reset all ones.
// - Channel flag sets on capture edge or compare equality.
// - Channel flag clears by read-while-set then zero write; events win.
// - Channel interrupt request follows flag and channel enable.
// - Channel 0 buffered select disables channel 1 and frees its pin.
// - With edge/level off, mode bit A sets initial output level.
// - Capture on rising, falling or either edge.
// - Compare match toggles, clears or sets the output.
// - Edge/level off leaves the pin to port logic.
// - Toggle-on-overflow toggles compare output at each wrap.
// - Overflow toggle beats a coincident compare action.
// - Full-duty bit, with overflow toggle and clear-on-compare, forces constant high from the next period.
// - Clear-on-compare without overflow toggle or full-duty bit keeps output low.
// - Capture loads count; high read blocks captures until low read.
// - Channel high write blocks compares until low write.
// - Buffered mode swaps to the last written pair at each wrap.
// - Clear control resets counter and prescaler, reads zero; halt resets set.
// - Wrap flag clears by read-then-zero; wrap interrupt when enabled.
`timescale 1ns/1ps
`default_nettype none
module ccpt_timer
    import ccpt_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output var logic [31:0] avs_readdata,
    output var logic avs_waitrequest,
    input wire logic ext_clock_pin,
    input wire logic [1:0] chan_pin_in,
    output var logic [1:0] chan_pin_out,
    output var logic [1:0] chan_pin_oe,
    output var logic wrap_irq,
    output var logic [1:0] chan_irq
);
    logic acc, rd_stb, wr_stb, clr, tick, tick_int, wrap_raw, wrap_evt, wrap_flag, buf_on;
    logic w_tsc, w_modh, w_modl, r_tsc, r_cnth, r_cntl;
    logic [7:0] idx, wdat, rsel;
    logic tsc_irqen_r, halt_r, mod_pend_r, lat_r, act_sel_r, last_wr_r;
    logic [2:0] ps_r;
    logic [5:0] presc_r, pmask;
    logic [15:0] cnt_r, cnt_nxt, mod_r;
    logic [7:0] lat_lo_r;
    logic [2:0] sync1_r, sync2_r, sync3_r, stable_r, stable_d_r, rise_v, fall_v;
    logic [6:0] sc_r [2];
    logic [15:0] val_r [2];
    logic [1:0] ch_flag, ch_evt, cmp_blk_r, cap_blk_r, out_r, maxeff_r, cmp_on, full_on, w_chh, w_chl;

    // Bus strobes: one access per request, answered one cycle later.
    assign acc = (avs_read || avs_write) && avs_waitrequest;
    assign rd_stb = acc && avs_read;
    assign wr_stb = acc && avs_write && avs_byteenable[0];
    assign idx = avs_address[9:2];
    assign wdat = avs_writedata[7:0];
    assign w_tsc = wr_stb && (idx == IDX_TSC);
    assign w_modh = wr_stb && (idx == IDX_MOD_HI);
    assign w_modl = wr_stb && (idx == IDX_MOD_LO);
    assign r_tsc = rd_stb && (idx == IDX_TSC);
    assign r_cnth = rd_stb && (idx == IDX_CNT_HI);
    assign r_cntl = rd_stb && (idx == IDX_CNT_LO);
    assign clr = w_tsc && wdat[TSC_CLEAR];
    assign buf_on = sc_r[0][SC_BUF];

    // Waitrequest drops for one cycle with the read data of the taken access.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (acc) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h000000, rsel};
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Byte-wide read mux; unmapped indices read zero.
    always_comb begin
        rsel = 8'h00;
        case (idx)
            IDX_TSC: rsel = {wrap_flag, tsc_irqen_r, halt_r, 2'h0, ps_r};
            IDX_CNT_HI: rsel = cnt_r[15:8];
            IDX_CNT_LO: rsel = lat_r ? lat_lo_r : cnt_r[7:0];
            IDX_MOD_HI: rsel = mod_r[15:8];
            IDX_MOD_LO: rsel = mod_r[7:0];
            IDX_SC0: rsel = {ch_flag[0], sc_r[0]};
            IDX_CH0_HI: rsel = val_r[0][15:8];
            IDX_CH0_LO: rsel = val_r[0][7:0];
            IDX_SC1: rsel = {ch_flag[1], sc_r[1]};
            IDX_CH1_HI: rsel = val_r[1][15:8];
            IDX_CH1_LO: rsel = val_r[1][7:0];
            default: rsel = 8'h00;
        endcase
    end

    // Halt resets set; clock select resets cleared.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tsc_irqen_r <= 1'b0;
            halt_r <= HALT_RST;
            ps_r <= PS_RST;
        end else if (w_tsc) begin
            tsc_irqen_r <= wdat[TSC_IRQEN];
            halt_r <= wdat[TSC_HALT];
            ps_r <= wdat[TSC_PS_HI:TSC_PS_LO];
        end
    end

    // Three-stage pin synchronisers; a level counts once stages two and three agree.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
            stable_r <= 3'h0;
            stable_d_r <= 3'h0;
        end else begin
            sync1_r <= {chan_pin_in, ext_clock_pin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= (sync2_r & sync3_r) | (stable_r & (sync2_r ^ sync3_r));
            stable_d_r <= stable_r;
        end
    end
    assign rise_v = stable_r & ~stable_d_r;
    assign fall_v = ~stable_r & stable_d_r;

    // Prescaler tap or external clock edge.
    assign pmask = 6'((7'h01 << ps_r) - 7'h01);
    assign tick_int = ((presc_r & pmask) == pmask);
    assign tick = !halt_r && !clr && ((ps_r == PS_EXT) ? rise_v[0] : tick_int);

    // Prescaler runs while not halted and is zeroed by the clear control.
    always_ff @(posedge clock) begin
        if (!rst_n || clr) begin
            presc_r <= 6'h00;
        end else if (!halt_r) begin
            presc_r <= 6'(presc_r + 6'h01);
        end
    end

    // Wrap at modulo and restart from zero.
    assign wrap_raw = tick && (cnt_r == mod_r);
    assign cnt_nxt = (cnt_r == mod_r) ? CNT_RST : 16'(cnt_r + 16'h0001);
    // Wrap flag held off while the modulo high byte is pending.
    assign wrap_evt = wrap_raw && !mod_pend_r;

    // Counter cleared by reset and by the clear control.
    always_ff @(posedge clock) begin
        if (!rst_n || clr) begin
            cnt_r <= CNT_RST;
        end else if (tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Modulo resets to all ones and pends between byte writes.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mod_r <= MOD_RST;
            mod_pend_r <= 1'b0;
        end else if (w_modh) begin
            mod_r[15:8] <= wdat;
            mod_pend_r <= 1'b1;
        end else if (w_modl) begin
            mod_r[7:0] <= wdat;
            mod_pend_r <= 1'b0;
        end
    end

    // Low byte latched by the first high read, released by a low read.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lat_r <= 1'b0;
            lat_lo_r <= 8'h00;
        end else if (r_cnth && !lat_r) begin
            lat_r <= 1'b1;
            lat_lo_r <= cnt_r[7:0];
        end else if (r_cntl) begin
            lat_r <= 1'b0;
        end
    end

    ccpt_evflag u_wrap_flag (
        .clock(clock),
        .rst_n(rst_n),
        .event_set(wrap_evt),
        .status_read(r_tsc),
        .status_write(w_tsc),
        .write_bit(wdat[TSC_FLAG]),
        .flag_r(wrap_flag)
    );

    // Buffered pair selection follows the last written pair at each wrap.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            last_wr_r <= 1'b0;
            act_sel_r <= 1'b0;
        end else begin
            if (w_chh[0] || w_chl[0]) begin
                last_wr_r <= 1'b0;
            end else if (w_chh[1] || w_chl[1]) begin
                last_wr_r <= 1'b1;
            end
            if (!buf_on) begin
                act_sel_r <= 1'b0;
            end else if (wrap_raw) begin
                act_sel_r <= last_wr_r;
            end
        end
    end

    for (genvar x = 0; x < 2; x++) begin : g_chan
        localparam logic [7:0] I_SC = (x == 0) ? IDX_SC0 : IDX_SC1;
        localparam logic [7:0] I_HI = (x == 0) ? IDX_CH0_HI : IDX_CH1_HI;
        localparam logic [7:0] I_LO = (x == 0) ? IDX_CH0_LO : IDX_CH1_LO;
        logic en, cap_mode, is_cap, is_cmp, edge_hit, cap_evt, match, blk, pair1;
        logic [1:0] els;
        logic [15:0] cmpv;

        // Channel 1 is off while channel 0 runs buffered.
        assign en = (x == 0) || !buf_on;
        assign els = sc_r[x][SC_ELS_HI:SC_ELS_LO];
        assign cap_mode = !sc_r[x][SC_BUF] && !sc_r[x][SC_MSA];
        assign is_cap = en && (els != ELS_OFF) && cap_mode;
        assign is_cmp = en && (els != ELS_OFF) && !cap_mode;
        assign w_chh[x] = wr_stb && (idx == I_HI);
        assign w_chl[x] = wr_stb && (idx == I_LO);
        assign pair1 = (x == 0) && buf_on && act_sel_r;
        assign cmpv = pair1 ? val_r[1] : val_r[x];
        assign blk = pair1 ? cmp_blk_r[1] : cmp_blk_r[x];

        assign edge_hit = ((els == ELS_RISE) && rise_v[x + 1]) || ((els == ELS_FALL) && fall_v[x + 1])
            || ((els == ELS_ANY) && (rise_v[x + 1] || fall_v[x + 1]));
        // Captures blocked by a pending high read and by halt.
        assign cap_evt = is_cap && edge_hit && !cap_blk_r[x] && !halt_r;
        // Compares blocked by a pending high write.
        assign match = is_cmp && tick && (cnt_nxt == cmpv) && !blk;
        // Channel event from capture or compare.
        assign ch_evt[x] = cap_evt || match;
        assign cmp_on[x] = is_cmp;
        assign full_on[x] = is_cmp && sc_r[x][SC_TOV] && (els == ELS_CLEAR) && maxeff_r[x];

        // Channel controls; writes to channel 1 dropped while disabled.
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                sc_r[x] <= SC_RST;
            end else if (wr_stb && (idx == I_SC) && en) begin
                sc_r[x] <= {wdat[SC_IRQEN], (x == 0) ? wdat[SC_BUF] : 1'b0, wdat[SC_MSA:SC_MAX]};
            end
        end

        ccpt_evflag u_chan_flag (
            .clock(clock),
            .rst_n(rst_n),
            .event_set(ch_evt[x]),
            .status_read(rd_stb && (idx == I_SC)),
            .status_write(wr_stb && (idx == I_SC) && en),
            .write_bit(wdat[SC_FLAG]),
            .flag_r(ch_flag[x])
        );

        // Channel value takes the count on capture; contents undefined after reset.
        always_ff @(posedge clock) begin
            if (cap_evt) begin
                val_r[x] <= cnt_r;
            end else if (w_chh[x]) begin
                val_r[x][15:8] <= wdat;
            end else if (w_chl[x]) begin
                val_r[x][7:0] <= wdat;
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                cap_blk_r[x] <= 1'b0;
                cmp_blk_r[x] <= 1'b0;
            end else begin
                if (rd_stb && (idx == I_HI) && cap_mode) begin
                    cap_blk_r[x] <= 1'b1;
                end else if (rd_stb && (idx == I_LO)) begin
                    cap_blk_r[x] <= 1'b0;
                end
                if (w_chh[x] && !cap_mode) begin
                    cmp_blk_r[x] <= 1'b1;
                end else if (w_chl[x]) begin
                    cmp_blk_r[x] <= 1'b0;
                end
            end
        end

        // Full-duty request sampled at each wrap.
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                maxeff_r[x] <= 1'b0;
            end else if (wrap_raw) begin
                maxeff_r[x] <= sc_r[x][SC_MAX];
            end
        end

        // Channel output level.
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                out_r[x] <= 1'b0;
            end else if (els == ELS_OFF) begin
                out_r[x] <= !sc_r[x][SC_MSA];
            end else if (is_cmp) begin
                if (full_on[x]) begin
                    out_r[x] <= 1'b1;
                end else if ((els == ELS_CLEAR) && !sc_r[x][SC_TOV] && !sc_r[x][SC_MAX]) begin
                    out_r[x] <= 1'b0;
                end else if (wrap_raw && sc_r[x][SC_TOV]) begin
                    out_r[x] <= !out_r[x];
                end else if (match) begin
                    case (els)
                        ELS_TOGGLE: out_r[x] <= !out_r[x];
                        ELS_CLEAR: out_r[x] <= 1'b0;
                        ELS_SET: out_r[x] <= 1'b1;
                        default: out_r[x] <= out_r[x];
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chan_pin_out <= 2'h0;
            chan_pin_oe <= 2'h0;
            chan_irq <= 2'h0;
            wrap_irq <= 1'b0;
        end else begin
            chan_pin_out <= out_r;
            chan_pin_oe <= cmp_on;
            chan_irq <= ch_flag & {sc_r[1][SC_IRQEN] && !buf_on, sc_r[0][SC_IRQEN]};
            wrap_irq <= wrap_flag && tsc_irqen_r;
        end
    end

    property p_halt_clear;
        @(posedge clock) disable iff (!rst_n)
            (w_tsc && wdat[TSC_HALT] && wdat[TSC_CLEAR]) |=> (cnt_r == 16'h0000) [*2];
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("Halt with clear did not hold zero.");

    property p_div2;
        @(posedge clock) disable iff (!rst_n) (tick && (ps_r == 3'h1) && !w_tsc) |=> !tick;
    endproperty
    a_div2: assert property (p_div2) else $error("Divide by two ticked twice in a row.");

    property p_latch_hold;
        @(posedge clock) disable iff (!rst_n) (lat_r && !r_cntl) |=> (lat_r && $stable(lat_lo_r));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latched low byte changed.");

    property p_clear;
        @(posedge clock) disable iff (!rst_n) clr |=> (cnt_r == 16'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not zero the counter.");

    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
            (tick && (cnt_r == mod_r) && !mod_pend_r) |=> ((cnt_r == 16'h0000) && wrap_flag);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Wrap did not restart and flag.");

    property p_mod_pend;
        @(posedge clock) disable iff (!rst_n) (mod_pend_r && !wrap_flag) |=> !wrap_flag;
    endproperty
    a_mod_pend: assert property (p_mod_pend) else $error("Wrap flag set while modulo pending.");

    property p_irq;
        @(posedge clock) disable iff (!rst_n) (ch_flag[0] && sc_r[0][SC_IRQEN]) |=> chan_irq[0];
    endproperty
    a_irq: assert property (p_irq) else $error("Channel interrupt missing.");

    property p_full;
        @(posedge clock) disable iff (!rst_n) full_on[0] |=> out_r[0] ##1 chan_pin_out[0];
    endproperty
    a_full: assert property (p_full) else $error("Full duty output not high.");

    property p_ch1_off;
        @(posedge clock) disable iff (!rst_n) buf_on |=> (!chan_pin_oe[1] && !chan_irq[1]);
    endproperty
    a_ch1_off: assert property (p_ch1_off) else $error("Channel 1 active in buffered mode.");

    c_wrap: cover property (@(posedge clock) disable iff (!rst_n) wrap_evt);
    c_capture: cover property (@(posedge clock) disable iff (!rst_n) ch_evt[0] && !cmp_on[0]);
    c_swap: cover property (@(posedge clock) disable iff (!rst_n) $rose(act_sel_r));
    c_full: cover property (@(posedge clock) disable iff (!rst_n) full_on[0]);
endmodule : ccpt_timer
`default_nettype wire

// ==== test/ccpt_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccpt_pins_model (
    input wire logic clock,
    input wire logic [1:0] level_req,
    output var logic [1:0] chan_pin_in,
    output var logic ext_clock_pin
);
    logic [1:0] div_r = 2'h0;
    // Channel pins follow the bench request one clock later and then stay put.
    // steady pin levels
    always @(posedge clock) begin
        chan_pin_in <= level_req;
    end
    // The external clock source runs free at a quarter of the bus rate.
    always @(posedge clock) begin
        div_r <= 2'(div_r + 2'h1);
        ext_clock_pin <= div_r[1];
    end
endmodule : ccpt_pins_model
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import ccpt_pkg::*; ();
    logic clock, rst_n, avs_read, avs_write, avs_waitrequest, ext_clock_pin, wrap_irq;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [1:0] chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq, level_req;
    logic [7:0] x;
    int fails = 0;
    int checked = 0;
    ccpt_timer ccpt_timer_inst (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_clock_pin(ext_clock_pin),
        .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
        .wrap_irq(wrap_irq), .chan_irq(chan_irq));
    ccpt_pins_model ccpt_pins_model_inst (.clock(clock), .level_req(level_req), .chan_pin_in(chan_pin_in),
        .ext_clock_pin(ext_clock_pin));
    // Free-running bus clock at 25 MHz.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // Compares one byte and reports a mismatch.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One bus access held until waitrequest is sampled low, then released.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        avs_address <= {idx, 2'h0};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, wd};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] t;
        bus(1'b1, idx, d, t);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] t;
        bus(1'b0, idx, 8'h00, t);
        check(t, exp);
    endtask : rdc
    // Watchdog that cuts a hang short.
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
    // Main sequence of register-level tests.
    initial begin
        rst_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, level_req} = '0;
        avs_byteenable = 4'h1;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rdc(IDX_TSC, 8'h20);
        rdc(IDX_MOD_HI, 8'hFF);
        rdc(IDX_MOD_LO, 8'hFF);
        rdc(IDX_SC0, 8'h00);
        rdc(8'h00, 8'h00);
        wr(IDX_TSC, 8'h30);
        rdc(IDX_CNT_HI, 8'h00);
        rdc(IDX_CNT_LO, 8'h00);
        rdc(IDX_TSC, 8'h20);
        wr(IDX_MOD_HI, 8'h00);
        wr(IDX_MOD_LO, 8'h03);
        wr(IDX_TSC, 8'h40);
        repeat (12) @(posedge clock);
        check({7'h0, wrap_irq}, 8'h01);
        wr(IDX_TSC, 8'h60);
        rdc(IDX_CNT_HI, 8'h00);
        bus(1'b0, IDX_CNT_LO, 8'h00, x);
        check({7'h0, x > 8'h03}, 8'h00);
        rdc(IDX_TSC, 8'hE0);
        wr(IDX_TSC, 8'h20);
        rdc(IDX_TSC, 8'h20);
        wr(IDX_TSC, 8'h00);
        wr(IDX_SC0, 8'h44);
        level_req <= 2'h1;
        repeat (8) @(posedge clock);
        rdc(IDX_SC0, 8'hC4);
        check({7'h0, chan_irq[0]}, 8'h01);
        wr(IDX_SC0, 8'h48);
        rdc(IDX_SC0, 8'h48);
        level_req <= 2'h0;
        repeat (8) @(posedge clock);
        rdc(IDX_SC0, 8'hC8);
        wr(IDX_CH1_HI, 8'h00);
        wr(IDX_CH1_LO, 8'h02);
        check({7'h0, chan_pin_oe[1]}, 8'h00);
        wr(IDX_SC1, 8'h10);
        repeat (2) @(posedge clock);
        check({6'h0, chan_pin_oe[1], chan_pin_out[1]}, 8'h00);
        wr(IDX_SC1, 8'h1C);
        repeat (12) @(posedge clock);
        check({6'h0, chan_pin_oe[1], chan_pin_out[1]}, 8'h03);
        rdc(IDX_SC1, 8'h9C);
        wr(IDX_SC1, 8'h18);
        repeat (12) @(posedge clock);
        check({7'h0, chan_pin_out[1]}, 8'h00);
        wr(IDX_SC0, 8'h28);
        repeat (4) @(posedge clock);
        check({7'h0, chan_pin_oe[1]}, 8'h00);
        // Count ticks over an even window of edges, so the prescaler phase cannot matter.
        wr(IDX_TSC, 8'h11);
        @(posedge clock);
        wr(IDX_TSC, 8'h21);
        rdc(IDX_CNT_LO, 8'h02);
        wr(IDX_TSC, 8'h17);
        repeat (5) @(posedge clock);
        wr(IDX_TSC, 8'h27);
        rdc(IDX_CNT_LO, 8'h02);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
